// *** hw/odl_pkg.sv ***
package odl_pkg;

  // decoded operation classes
  typedef enum logic [5:0] {
    odl_op_none          = 6'h00,
    odl_op_rotate_left   = 6'h01,
    odl_op_rotate_right  = 6'h02,
    odl_op_rot_carry_l   = 6'h03,
    odl_op_rot_carry_r   = 6'h04,
    odl_op_arith_shr     = 6'h05,
    odl_op_and           = 6'h06,
    odl_op_or            = 6'h07,
    odl_op_xor           = 6'h08,
    odl_op_test          = 6'h09,
    odl_op_iterate       = 6'h0a,
    odl_op_string_copy   = 6'h0b,
    odl_op_string_cmp    = 6'h0c,
    odl_op_string_scan   = 6'h0d,
    odl_op_string_load   = 6'h0e,
    odl_op_string_store  = 6'h0f,
    odl_op_call_near     = 6'h10,
    odl_op_call_far      = 6'h11,
    odl_op_call_near_ind = 6'h12,
    odl_op_call_far_ind  = 6'h13,
    odl_op_br_near       = 6'h14,
    odl_op_br_short      = 6'h15,
    odl_op_br_far        = 6'h16,
    odl_op_br_near_ind   = 6'h17,
    odl_op_br_far_ind    = 6'h18,
    odl_op_exit_near     = 6'h19,
    odl_op_exit_far      = 6'h1a,
    odl_op_cond_branch   = 6'h1b,
    odl_op_loop          = 6'h1c,
    odl_op_loop_zero     = 6'h1d,
    odl_op_loop_nzero    = 6'h1e,
    odl_op_br_count_zero = 6'h1f,
    odl_op_trap          = 6'h20,
    odl_op_trap3         = 6'h21,
    odl_op_trap_ovf      = 6'h22,
    odl_op_carry_clear   = 6'h23,
    odl_op_carry_flip    = 6'h24,
    odl_op_carry_set     = 6'h25,
    odl_op_invalid       = 6'h3f
  } odl_op_t;

  // decoder sequencing
  typedef enum logic [2:0] {
    odl_st_opcode = 3'b001,
    odl_st_modrm  = 3'b010,
    odl_st_tail   = 3'b100
  } odl_state_t;

  // opcode families (fixed bits only)
  localparam logic [7:0] ODL_SHIFT_GRP   = 8'hd0; // 110100vw
  localparam logic [7:0] ODL_AND_RM      = 8'h20; // 001000dw
  localparam logic [7:0] ODL_OR_RM       = 8'h08; // 000010dw
  localparam logic [7:0] ODL_XOR_RM      = 8'h30; // 001100dw
  localparam logic [7:0] ODL_IMM_GRP     = 8'h80; // 1000000w
  localparam logic [7:0] ODL_AND_ACC     = 8'h24; // 0010010w
  localparam logic [7:0] ODL_OR_ACC      = 8'h0c; // 0000110w
  localparam logic [7:0] ODL_XOR_ACC     = 8'h34; // 0011010w
  localparam logic [7:0] ODL_TEST_RM     = 8'h84; // 1000010w
  localparam logic [7:0] ODL_TEST_IMM    = 8'hf6; // 1111011w
  localparam logic [7:0] ODL_TEST_ACC    = 8'ha8; // 1010100w
  localparam logic [7:0] ODL_ITER_PFX    = 8'hf2; // 1111001z
  localparam logic [7:0] ODL_STR_COPY    = 8'ha4;
  localparam logic [7:0] ODL_STR_CMP     = 8'ha6;
  localparam logic [7:0] ODL_STR_SCAN    = 8'hae;
  localparam logic [7:0] ODL_STR_LOAD    = 8'hac;
  localparam logic [7:0] ODL_STR_STORE   = 8'haa;
  localparam logic [7:0] ODL_CALL_NEAR   = 8'he8;
  localparam logic [7:0] ODL_CALL_FAR    = 8'h9a;
  localparam logic [7:0] ODL_IND_GRP     = 8'hff;
  localparam logic [7:0] ODL_BR_NEAR     = 8'he9;
  localparam logic [7:0] ODL_BR_SHORT    = 8'heb;
  localparam logic [7:0] ODL_BR_FAR      = 8'hea;
  localparam logic [7:0] ODL_EXIT_NEAR   = 8'hc3;
  localparam logic [7:0] ODL_EXIT_NEAR_I = 8'hc2;
  localparam logic [7:0] ODL_EXIT_FAR    = 8'hcb;
  localparam logic [7:0] ODL_EXIT_FAR_I  = 8'hca;
  localparam logic [7:0] ODL_COND_BASE   = 8'h70; // 0111cccc
  localparam logic [7:0] ODL_LOOP_NZF    = 8'he0;
  localparam logic [7:0] ODL_LOOP_ZF     = 8'he1;
  localparam logic [7:0] ODL_LOOP        = 8'he2;
  localparam logic [7:0] ODL_BR_CNT_ZERO = 8'he3;
  localparam logic [7:0] ODL_TRAP3       = 8'hcc;
  localparam logic [7:0] ODL_TRAP        = 8'hcd;
  localparam logic [7:0] ODL_TRAP_OVF    = 8'hce;
  localparam logic [7:0] ODL_CARRY_CLEAR = 8'hf8;
  localparam logic [7:0] ODL_CARRY_FLIP  = 8'hf5;
  localparam logic [7:0] ODL_CARRY_SET   = 8'hf9;

  // addressing-byte extension codes
  localparam logic [2:0] ODL_EXT_ROL  = 3'h0;
  localparam logic [2:0] ODL_EXT_ROR  = 3'h1;
  localparam logic [2:0] ODL_EXT_RCL  = 3'h2;
  localparam logic [2:0] ODL_EXT_RCR  = 3'h3;
  localparam logic [2:0] ODL_EXT_SAR  = 3'h7;
  localparam logic [2:0] ODL_EXT_AND  = 3'h4;
  localparam logic [2:0] ODL_EXT_OR   = 3'h5;
  localparam logic [2:0] ODL_EXT_XOR  = 3'h6;
  localparam logic [2:0] ODL_EXT_TEST = 3'h0;
  localparam logic [2:0] ODL_EXT_CN   = 3'h2;
  localparam logic [2:0] ODL_EXT_CF   = 3'h3;
  localparam logic [2:0] ODL_EXT_BN   = 3'h4;
  localparam logic [2:0] ODL_EXT_BF   = 3'h5;

  // fixed trap type of the single-byte trap
  localparam logic [7:0] ODL_TRAP3_TYPE = 8'h03;
  localparam logic [3:0] ODL_LEN_W      = 4'h0;

endpackage

// *** hw/odl_modrm_len.sv ***
`timescale 1ns/1ps
// extra bytes implied by the addressing byte (displacement)
module odl_modrm_len
  import odl_pkg::*;
(
  input  wire logic [7:0] modrm,
  output logic      [2:0] disp_bytes
);
  always_comb begin
    case (modrm[7:6])
      2'b00:   disp_bytes = (modrm[2:0] == 3'h6) ? 3'h2 : 3'h0;
      2'b01:   disp_bytes = 3'h1;
      2'b10:   disp_bytes = 3'h2;
      default: disp_bytes = 3'h0;
    endcase
  end
endmodule

// *** hw/odl_decoder.sv ***
`timescale 1ns/1ps
// How it works
// - 110100vw shift group, extension picks operation
// - and: register, immediate extension 100, accumulator
// - 1000010w flag-only and, register forms
// - 1111011w extension 000 flag-only and immediate
// - 1010100w flag-only and with accumulator
// - or/xor register, accumulator, extensions 101/110
// - 1111001z iterate prefix; 1010010w string copy
// - 1010011w string compare; 1010111w string scan
// - 1010110w string load; 1010101w string store
// - near call disp; far call offset+segment
// - 11111111 extensions 010/011/100/101 indirect transfers
// - unconditional branches: near, short, far
// - near exit, plain or with immediate
// - far exit, plain or with immediate
// - branch on equal and unequal, disp byte
// - signed comparison branches, disp byte
// - unsigned comparison branches, disp byte
// - overflow, sign, parity branches and negations
// - count loops with one disp byte
// - 11100011 branch if count register zero
// - traps: typed, type 3, on overflow
// - carry clear, flip, set single bytes
// - width bit selects word or byte
// - direction bit: 1 register is destination
// - count-source bit: one or count register low
// - prefix low bit ends compare/scan iteration
module odl_decoder
  import odl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  output logic            dec_valid_ff,
  output odl_op_t         dec_op_ff,
  output logic            dec_word_ff,
  output logic            dec_reg_dest_ff,
  output logic            dec_count_reg_ff,
  output logic            dec_flags_only_ff,
  output logic            dec_has_modrm_ff,
  output logic [7:0]      dec_modrm_ff,
  output logic [3:0]      dec_cond_ff,
  output logic            dec_iter_ff,
  output logic            dec_iter_zf_ff,
  output logic [31:0]     dec_tail_ff,
  output logic [3:0]      dec_len_ff
);

  odl_state_t  st_ff,      nxt_st;
  odl_op_t     op_ff,      nxt_op;
  logic        word_ff,    nxt_word;
  logic        dir_ff,     nxt_dir;
  logic        cnt_ff,     nxt_cnt;
  logic        fonly_ff,   nxt_fonly;
  logic        hasm_ff,    nxt_hasm;
  logic [7:0]  modrm_ff,   nxt_modrm;
  logic [3:0]  cond_ff,    nxt_cond;
  logic        iter_ff,    nxt_iter;
  logic        iterz_ff,   nxt_iterz;
  logic [2:0]  imm_ff,     nxt_imm;
  logic [2:0]  left_ff,    nxt_left;
  logic [1:0]  tidx_ff,    nxt_tidx;
  logic [31:0] tail_ff,    nxt_tail;
  logic [3:0]  len_ff,     nxt_len;
  logic        ov_ff,      nxt_ov;
  odl_op_t     ov_op_ff,   nxt_ov_op;
  logic [31:0] ov_tail_ff, nxt_ov_tail;
  logic [3:0]  ov_len_ff,  nxt_ov_len;
  logic [2:0]  disp_bytes;
  logic [2:0]  ext;

  assign ext = byte_data[5:3];

  odl_modrm_len u_modrm_len (
    .modrm      (byte_data),
    .disp_bytes (disp_bytes)
  );

  always_comb begin
    odl_op_t    o;
    logic       m;
    logic [2:0] n;
    o = odl_op_invalid;
    m = 1'b0;
    n = 3'h0;
    nxt_st      = st_ff;
    nxt_op      = op_ff;
    nxt_word    = word_ff;
    nxt_dir     = dir_ff;
    nxt_cnt     = cnt_ff;
    nxt_fonly   = fonly_ff;
    nxt_hasm    = hasm_ff;
    nxt_modrm   = modrm_ff;
    nxt_cond    = cond_ff;
    nxt_iter    = iter_ff;
    nxt_iterz   = iterz_ff;
    nxt_imm     = imm_ff;
    nxt_left    = left_ff;
    nxt_tidx    = tidx_ff;
    nxt_tail    = tail_ff;
    nxt_len     = len_ff;
    nxt_ov      = 1'b0;
    nxt_ov_op   = ov_op_ff;
    nxt_ov_tail = ov_tail_ff;
    nxt_ov_len  = ov_len_ff;
    if (byte_valid) begin
      case (st_ff)
        odl_st_opcode: begin
          nxt_len   = 4'(len_ff + 4'h1);
          nxt_word  = byte_data[0];
          nxt_dir   = byte_data[1];
          nxt_cnt   = byte_data[1];
          nxt_fonly = 1'b0;
          nxt_cond  = 4'h0;
          nxt_tail  = 32'h0;
          nxt_tidx  = 2'h0;
          nxt_modrm = 8'h0;
          if ((byte_data & 8'hfc) == ODL_SHIFT_GRP) m = 1'b1;
          else if ((byte_data & 8'hfc) == ODL_AND_RM) m = 1'b1;
          else if ((byte_data & 8'hfc) == ODL_OR_RM) m = 1'b1;
          else if ((byte_data & 8'hfc) == ODL_XOR_RM) m = 1'b1;
          else if ((byte_data & 8'hfe) == ODL_IMM_GRP) m = 1'b1;
          else if ((byte_data & 8'hfe) == ODL_TEST_RM) m = 1'b1;
          else if ((byte_data & 8'hfe) == ODL_TEST_IMM) m = 1'b1;
          else if (byte_data == ODL_IND_GRP) m = 1'b1;
          if ((byte_data & 8'hfe) == ODL_AND_ACC) o = odl_op_and;
          else if ((byte_data & 8'hfe) == ODL_OR_ACC) o = odl_op_or;
          else if ((byte_data & 8'hfe) == ODL_XOR_ACC) o = odl_op_xor;
          else if ((byte_data & 8'hfe) == ODL_TEST_ACC) o = odl_op_test;
          else if ((byte_data & 8'hfe) == ODL_STR_CMP) o = odl_op_string_cmp;
          else if ((byte_data & 8'hfe) == ODL_STR_SCAN) o = odl_op_string_scan;
          else if ((byte_data & 8'hfe) == ODL_STR_LOAD) o = odl_op_string_load;
          else if ((byte_data & 8'hfe) == ODL_STR_STORE)
            o = odl_op_string_store;
          else if ((byte_data & 8'hfe) == ODL_STR_COPY) o = odl_op_string_copy;
          else if ((byte_data & 8'hfe) == ODL_ITER_PFX) o = odl_op_iterate;
          else if ((byte_data & 8'hf0) == ODL_COND_BASE) o = odl_op_cond_branch;
          else begin
            case (byte_data)
              ODL_CALL_NEAR:   o = odl_op_call_near;
              ODL_CALL_FAR:    o = odl_op_call_far;
              ODL_BR_NEAR:     o = odl_op_br_near;
              ODL_BR_SHORT:    o = odl_op_br_short;
              ODL_BR_FAR:      o = odl_op_br_far;
              ODL_EXIT_NEAR,
              ODL_EXIT_NEAR_I: o = odl_op_exit_near;
              ODL_EXIT_FAR,
              ODL_EXIT_FAR_I:  o = odl_op_exit_far;
              ODL_LOOP:        o = odl_op_loop;
              ODL_LOOP_ZF:     o = odl_op_loop_zero;
              ODL_LOOP_NZF:    o = odl_op_loop_nzero;
              ODL_BR_CNT_ZERO: o = odl_op_br_count_zero;
              ODL_TRAP:        o = odl_op_trap;
              ODL_TRAP3:       o = odl_op_trap3;
              ODL_TRAP_OVF:    o = odl_op_trap_ovf;
              ODL_CARRY_CLEAR: o = odl_op_carry_clear;
              ODL_CARRY_FLIP:  o = odl_op_carry_flip;
              ODL_CARRY_SET:   o = odl_op_carry_set;
              default:         o = m ? odl_op_none : odl_op_invalid;
            endcase
          end
          // trailing byte counts per opcode
          case (o)
            odl_op_and, odl_op_or, odl_op_xor, odl_op_test:
              n = byte_data[0] ? 3'h2 : 3'h1;
            odl_op_call_near, odl_op_br_near: n = 3'h2;
            odl_op_call_far, odl_op_br_far:   n = 3'h4;
            odl_op_exit_near, odl_op_exit_far:
              n = byte_data[0] ? 3'h0 : 3'h2;
            odl_op_cond_branch, odl_op_loop, odl_op_loop_zero,
            odl_op_loop_nzero, odl_op_br_count_zero, odl_op_br_short,
            odl_op_trap: n = 3'h1;
            default: n = 3'h0;
          endcase
          nxt_cond  = byte_data[3:0];
          nxt_fonly = (o == odl_op_test) || ((byte_data & 8'hfe) == ODL_TEST_RM);
          if ((byte_data & 8'hfe) == ODL_TEST_RM) o = odl_op_test;
          if ((byte_data & 8'hfc) == ODL_AND_RM) o = odl_op_and;
          if ((byte_data & 8'hfc) == ODL_OR_RM) o = odl_op_or;
          if ((byte_data & 8'hfc) == ODL_XOR_RM) o = odl_op_xor;
          if (o == odl_op_trap3) nxt_tail = {24'h0, ODL_TRAP3_TYPE};
          nxt_op   = o;
          nxt_hasm = m;
          nxt_imm  = ((byte_data & 8'hfe) == ODL_IMM_GRP ||
                      (byte_data & 8'hfe) == ODL_TEST_IMM) ?
                     (byte_data[0] ? 3'h2 : 3'h1) : n;
          if (o == odl_op_iterate) begin
            nxt_iter  = 1'b1;
            nxt_iterz = byte_data[0];
          end else if (m) begin
            nxt_st = odl_st_modrm;
          end else if (n != 3'h0) begin
            nxt_left = n;
            nxt_st   = odl_st_tail;
          end else begin
            nxt_ov = 1'b1;
          end
        end
        odl_st_modrm: begin
          nxt_len   = 4'(len_ff + 4'h1);
          nxt_modrm = byte_data;
          o = op_ff;
          n = 3'h0;
          if (op_ff == odl_op_none) begin
            o = odl_op_invalid;
            // immediate count and low opcode nibble tell the addressing-byte groups apart
            if (imm_ff != 3'h0 && cond_ff[2]) begin
              if (ext == ODL_EXT_TEST) begin
                o         = odl_op_test;
                n         = imm_ff;
                nxt_fonly = 1'b1;
              end
            end else if (imm_ff != 3'h0) begin
              n = imm_ff;
              if (ext == ODL_EXT_AND)      o = odl_op_and;
              else if (ext == ODL_EXT_OR)  o = odl_op_or;
              else if (ext == ODL_EXT_XOR) o = odl_op_xor;
              else                         n = 3'h0;
            end else if (cond_ff == 4'hf) begin
              case ({1'b0, ext})
                4'(ODL_EXT_CN): o = odl_op_call_near_ind;
                4'(ODL_EXT_CF): o = odl_op_call_far_ind;
                4'(ODL_EXT_BN): o = odl_op_br_near_ind;
                4'(ODL_EXT_BF): o = odl_op_br_far_ind;
                default:        o = odl_op_invalid;
              endcase
            end else begin
              case ({1'b0, ext})
                4'(ODL_EXT_ROL): o = odl_op_rotate_left;
                4'(ODL_EXT_ROR): o = odl_op_rotate_right;
                4'(ODL_EXT_RCL): o = odl_op_rot_carry_l;
                4'(ODL_EXT_RCR): o = odl_op_rot_carry_r;
                4'(ODL_EXT_SAR): o = odl_op_arith_shr;
                default:         o = odl_op_invalid;
              endcase
            end
          end
          nxt_op = o;
          nxt_left = 3'(disp_bytes + n);
          if (3'(disp_bytes + n) == 3'h0) begin
            nxt_ov = 1'b1;
            nxt_st = odl_st_opcode;
          end else begin
            nxt_st = odl_st_tail;
          end
        end
        odl_st_tail: begin
          nxt_len = 4'(len_ff + 4'h1);
          nxt_tail[8*tidx_ff +: 8] = byte_data;
          nxt_tidx = 2'(tidx_ff + 2'h1);
          nxt_left = 3'(left_ff - 3'h1);
          if (left_ff == 3'h1) begin
            nxt_ov = 1'b1;
            nxt_st = odl_st_opcode;
          end
        end
        default: nxt_st = odl_st_opcode;
      endcase
    end
    if (nxt_ov) begin
      nxt_ov_op   = nxt_op;
      nxt_ov_tail = nxt_tail;
      nxt_ov_len  = nxt_len;
      nxt_len     = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= odl_st_opcode; op_ff <= odl_op_none; word_ff <= 1'b0;
      dir_ff <= 1'b0; cnt_ff <= 1'b0; fonly_ff <= 1'b0; hasm_ff <= 1'b0;
      modrm_ff <= 8'h0; cond_ff <= 4'h0; iter_ff <= 1'b0; iterz_ff <= 1'b0;
      imm_ff <= 3'h0; left_ff <= 3'h0; tidx_ff <= 2'h0; tail_ff <= 32'h0;
      len_ff <= 4'h0; ov_ff <= 1'b0; ov_op_ff <= odl_op_none;
      ov_tail_ff <= 32'h0; ov_len_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st; op_ff <= nxt_op; word_ff <= nxt_word;
      dir_ff <= nxt_dir; cnt_ff <= nxt_cnt; fonly_ff <= nxt_fonly;
      hasm_ff <= nxt_hasm; modrm_ff <= nxt_modrm; cond_ff <= nxt_cond;
      iter_ff <= nxt_ov ? 1'b0 : nxt_iter; iterz_ff <= nxt_iterz;
      imm_ff <= nxt_imm; left_ff <= nxt_left; tidx_ff <= nxt_tidx;
      tail_ff <= nxt_tail; len_ff <= nxt_len; ov_ff <= nxt_ov;
      ov_op_ff <= nxt_ov_op; ov_tail_ff <= nxt_ov_tail;
      ov_len_ff <= nxt_ov_len;
    end
  end

  // registered result bundle, updated once per instruction
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dec_valid_ff <= 1'b0; dec_op_ff <= odl_op_none; dec_word_ff <= 1'b0;
      dec_reg_dest_ff <= 1'b0; dec_count_reg_ff <= 1'b0;
      dec_flags_only_ff <= 1'b0; dec_has_modrm_ff <= 1'b0;
      dec_modrm_ff <= 8'h0; dec_cond_ff <= 4'h0; dec_iter_ff <= 1'b0;
      dec_iter_zf_ff <= 1'b0; dec_tail_ff <= 32'h0; dec_len_ff <= 4'h0;
    end else begin
      dec_valid_ff <= nxt_ov;
      if (nxt_ov) begin
        dec_op_ff <= nxt_ov_op; dec_word_ff <= nxt_word;
        dec_reg_dest_ff <= nxt_dir; dec_count_reg_ff <= nxt_cnt;
        dec_flags_only_ff <= nxt_fonly; dec_has_modrm_ff <= nxt_hasm;
        dec_modrm_ff <= nxt_modrm; dec_cond_ff <= nxt_cond;
        dec_iter_ff <= nxt_iter; dec_iter_zf_ff <= nxt_iterz;
        dec_tail_ff <= nxt_ov_tail; dec_len_ff <= nxt_ov_len;
      end
    end
  end

endmodule

// *** test/odl_fetch_model.sv ***
`timescale 1ns/1ps
module odl_fetch_model (
  input  wire logic       clk_sys,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h5a;
  end
  // idle cycles scramble the data lines
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      byte_valid <= 1'b0;
      byte_data  <= ~byte_data;
    end
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge clk_sys);
    byte_valid <= 1'b1;
    byte_data  <= b;
  endtask
endmodule

// *** test/odl_decoder_chk.sv ***
`timescale 1ns/1ps
module odl_decoder_chk
  import odl_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        byte_valid,
  input wire logic [7:0]  byte_data,
  input wire logic        dec_valid_ff,
  input odl_op_t          dec_op_ff,
  input wire logic        dec_flags_only_ff,
  input wire logic        dec_has_modrm_ff,
  input wire logic [7:0]  dec_modrm_ff,
  input wire logic        dec_iter_ff,
  input wire logic [31:0] dec_tail_ff,
  input wire logic [3:0]  dec_len_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  answer_cause_a: assert property (dec_valid_ff |-> $past(byte_valid))
    else $error("decode pulse without a byte taken");
  hold_out_a: assert property (!dec_valid_ff |->
    $stable(dec_op_ff) && $stable(dec_len_ff))
    else $error("outputs moved without a pulse");
  len_range_a: assert property (dec_valid_ff |->
    dec_len_ff >= 4'h1 && dec_len_ff <= 4'h7)
    else $error("length out of range");
  sar_ext_a: assert property (dec_valid_ff && dec_op_ff == odl_op_arith_shr
    |-> dec_has_modrm_ff && dec_modrm_ff[5:3] == 3'h7)
    else $error("arith shift extension wrong");
  rot_ext_a: assert property (dec_valid_ff && dec_op_ff inside
    {[odl_op_rotate_left:odl_op_rot_carry_r]}
    |-> dec_modrm_ff[5:3] == dec_op_ff[2:0] - 3'h1)
    else $error("rotate extension wrong");
  test_flags_a: assert property (dec_valid_ff |->
    dec_flags_only_ff == (dec_op_ff == odl_op_test))
    else $error("flag-only marking wrong");
  cond_disp_a: assert property (dec_valid_ff && dec_op_ff == odl_op_cond_branch
    |-> dec_len_ff == 4'h2 && dec_tail_ff[7:0] == $past(byte_data))
    else $error("branch displacement wrong");
  trap3_type_a: assert property (dec_valid_ff && dec_op_ff == odl_op_trap3
    && !dec_iter_ff |-> dec_len_ff == 4'h1 && dec_tail_ff[7:0] == 8'h03)
    else $error("type 3 trap wrong");
  carry_len_a: assert property (dec_valid_ff && !dec_iter_ff && dec_op_ff
    inside {[odl_op_carry_clear:odl_op_carry_set]}
    |-> dec_len_ff == 4'h1 && !dec_has_modrm_ff)
    else $error("carry control length wrong");
  far_len_a: assert property (dec_valid_ff && !dec_iter_ff && dec_op_ff
    inside {odl_op_call_far, odl_op_br_far} |-> dec_len_ff == 4'h5)
    else $error("far transfer length wrong");
endmodule
bind odl_decoder odl_decoder_chk odl_decoder_chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .byte_valid(byte_valid),
  .byte_data(byte_data), .dec_valid_ff(dec_valid_ff),
  .dec_op_ff(dec_op_ff), .dec_flags_only_ff(dec_flags_only_ff),
  .dec_has_modrm_ff(dec_has_modrm_ff), .dec_modrm_ff(dec_modrm_ff),
  .dec_iter_ff(dec_iter_ff), .dec_tail_ff(dec_tail_ff),
  .dec_len_ff(dec_len_ff));

// *** test/opcode_decoder_logic_branch_bench.sv ***
`timescale 1ns/1ps
module opcode_decoder_logic_branch_bench;
  import odl_pkg::*;
  logic        clk_sys, arst_n, byte_valid, dec_valid_ff, dec_word_ff;
  logic        dec_reg_dest_ff, dec_count_reg_ff, dec_flags_only_ff;
  logic        dec_has_modrm_ff, dec_iter_ff, dec_iter_zf_ff;
  logic [7:0]  byte_data, dec_modrm_ff;
  logic [3:0]  dec_cond_ff, dec_len_ff;
  logic [31:0] dec_tail_ff;
  odl_op_t     dec_op_ff;
  int          n_fail, cmp_count;
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  odl_fetch_model odl_fetch_model_i (.clk_sys(clk_sys),
    .byte_valid(byte_valid), .byte_data(byte_data));
  odl_decoder odl_decoder_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .dec_valid_ff(dec_valid_ff), .dec_op_ff(dec_op_ff),
    .dec_word_ff(dec_word_ff), .dec_reg_dest_ff(dec_reg_dest_ff),
    .dec_count_reg_ff(dec_count_reg_ff),
    .dec_flags_only_ff(dec_flags_only_ff),
    .dec_has_modrm_ff(dec_has_modrm_ff), .dec_modrm_ff(dec_modrm_ff),
    .dec_cond_ff(dec_cond_ff), .dec_iter_ff(dec_iter_ff),
    .dec_iter_zf_ff(dec_iter_zf_ff), .dec_tail_ff(dec_tail_ff),
    .dec_len_ff(dec_len_ff));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // feed bytes, wait for the pulse, judge class, length, tail bytes
  task automatic ri(input string nm, input logic [7:0] b[$],
                    input odl_op_t op, input int len,
                    input logic [31:0] tl = 32'h0, input int nt = 0,
                    input int gap = 0);
    int          k;
    logic [31:0] m;
    m = (nt == 0) ? 32'h0 : 32'hffffffff >> (32 - 8 * nt);
    foreach (b[i]) begin
      if (i > 0) odl_fetch_model_i.idle(gap);
      odl_fetch_model_i.put(b[i]);
    end
    odl_fetch_model_i.idle(1);
    #1;
    k = 0;
    while (dec_valid_ff !== 1'b1 && k < 8) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk({nm, " valid"}, 32'h1, {31'h0, dec_valid_ff});
    chk({nm, " op"}, {26'h0, op}, {26'h0, dec_op_ff});
    chk({nm, " len"}, {28'h0, 4'(len)}, {28'h0, dec_len_ff});
    chk({nm, " tail"}, tl & m, dec_tail_ff & m);
  endtask
  task automatic t_shift;
    logic [2:0] ex[5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
    odl_op_t    op[5] = '{odl_op_arith_shr, odl_op_rotate_left,
      odl_op_rotate_right, odl_op_rot_carry_l, odl_op_rot_carry_r};
    for (int i = 0; i < 5; i++) begin
      ri("shift", '{8'hd3, {2'b11, ex[i], 3'h1}}, op[i], 2);
      chk("count src", 32'h1, {31'h0, dec_count_reg_ff});
      chk("shift modrm", {24'h0, 2'b11, ex[i], 3'h1}, {24'h0, dec_modrm_ff});
    end
    ri("shift one", '{8'hd0, 8'hc0}, odl_op_rotate_left, 2);
    chk("count one", 32'h0, {31'h0, dec_count_reg_ff});
    chk("byte width", 32'h0, {31'h0, dec_word_ff});
  endtask
  task automatic t_logic;
    ri("and rm", '{8'h22, 8'hc8}, odl_op_and, 2);
    chk("dest", 32'h1, {31'h0, dec_reg_dest_ff});
    ri("and rm0", '{8'h20, 8'hc8}, odl_op_and, 2);
    chk("src", 32'h0, {31'h0, dec_reg_dest_ff});
    ri("and imm", '{8'h81, 8'he1, 8'h34, 8'h12}, odl_op_and, 4, 32'h1234, 2);
    chk("word", 32'h1, {31'h0, dec_word_ff});
    ri("and acc", '{8'h24, 8'h7e}, odl_op_and, 2, 32'h7e, 1);
    ri("or imm", '{8'h80, 8'he9, 8'h55}, odl_op_or, 3, 32'h55, 1);
    ri("xor imm", '{8'h80, 8'hf1, 8'h66}, odl_op_xor, 3, 32'h66, 1);
    ri("or rm", '{8'h0b, 8'hc1}, odl_op_or, 2);
    ri("xor rm", '{8'h30, 8'hc1}, odl_op_xor, 2);
    ri("xor acc", '{8'h35, 8'hcd, 8'hab}, odl_op_xor, 3, 32'habcd, 2);
    ri("test rm", '{8'h85, 8'hc1}, odl_op_test, 2);
    chk("flags only", 32'h1, {31'h0, dec_flags_only_ff});
    chk("has modrm", 32'h1, {31'h0, dec_has_modrm_ff});
    ri("test imm w", '{8'hf7, 8'hc1, 8'h22, 8'h11}, odl_op_test, 4, 32'h1122, 2);
    ri("test imm b", '{8'hf6, 8'hc1, 8'h22}, odl_op_test, 3, 32'h22, 1);
    ri("test acc w", '{8'ha9, 8'h44, 8'h33}, odl_op_test, 3, 32'h3344, 2);
    ri("test acc b", '{8'ha8, 8'h44}, odl_op_test, 2, 32'h44, 1);
  endtask
  task automatic t_string;
    ri("iter cmp", '{8'hf3, 8'ha6}, odl_op_string_cmp, 2, 0, 0, 2);
    chk("iter", 32'h1, {31'h0, dec_iter_ff});
    chk("iter zf1", 32'h1, {31'h0, dec_iter_zf_ff});
    ri("iter scan", '{8'hf2, 8'haf}, odl_op_string_scan, 2);
    chk("iter zf0", 32'h0, {31'h0, dec_iter_zf_ff});
    ri("copy", '{8'ha5}, odl_op_string_copy, 1);
    chk("no iter", 32'h0, {31'h0, dec_iter_ff});
    ri("load", '{8'had}, odl_op_string_load, 1);
    ri("store", '{8'haa}, odl_op_string_store, 1);
  endtask
  task automatic t_xfer;
    odl_op_t io[4] = '{odl_op_call_near_ind, odl_op_call_far_ind,
      odl_op_br_near_ind, odl_op_br_far_ind};
    ri("call n", '{8'he8, 8'h34, 8'h12}, odl_op_call_near, 3, 32'h1234, 2);
    ri("call f", '{8'h9a, 8'h34, 8'h12, 8'h78, 8'h56}, odl_op_call_far, 5, 32'h56781234, 4);
    for (int i = 0; i < 4; i++)
      ri("ind", '{8'hff, 8'hd0 + 8'(8 * i)}, io[i], 2);
    ri("br n", '{8'he9, 8'hcd, 8'hab}, odl_op_br_near, 3, 32'habcd, 2);
    ri("br s", '{8'heb, 8'h9c}, odl_op_br_short, 2, 32'h9c, 1);
    ri("br f", '{8'hea, 8'h01, 8'h02, 8'h03, 8'h04}, odl_op_br_far, 5, 32'h04030201, 4);
    ri("exit n", '{8'hc3}, odl_op_exit_near, 1);
    ri("exit ni", '{8'hc2, 8'h08, 8'h00}, odl_op_exit_near, 3, 32'h0008, 2);
    ri("exit f", '{8'hcb}, odl_op_exit_far, 1);
    ri("exit fi", '{8'hca, 8'hfe, 8'hff}, odl_op_exit_far, 3, 32'hfffe, 2);
  endtask
  task automatic t_branch;
    for (int c = 0; c < 16; c++) begin
      ri("cond", '{8'h70 + 8'(c), 8'(c) ^ 8'ha5}, odl_op_cond_branch, 2, 32'(c) ^ 32'ha5, 1);
      chk("cond code", 32'(c), {28'h0, dec_cond_ff});
    end
    ri("loop", '{8'he2, 8'hf0}, odl_op_loop, 2, 32'hf0, 1);
    ri("loop z", '{8'he1, 8'hf1}, odl_op_loop_zero, 2, 32'hf1, 1);
    ri("loop nz", '{8'he0, 8'hf2}, odl_op_loop_nzero, 2, 32'hf2, 1);
    ri("cnt zero", '{8'he3, 8'hf3}, odl_op_br_count_zero, 2, 32'hf3, 1);
    ri("trap", '{8'hcd, 8'h21}, odl_op_trap, 2, 32'h21, 1);
    ri("trap3", '{8'hcc}, odl_op_trap3, 1, 32'h03, 1);
    ri("trap ovf", '{8'hce}, odl_op_trap_ovf, 1);
    ri("clear", '{8'hf8}, odl_op_carry_clear, 1);
    ri("flip", '{8'hf5}, odl_op_carry_flip, 1);
    ri("set", '{8'hf9}, odl_op_carry_set, 1);
  endtask
  // reset in mid-instruction, then decode from a clean start
  task automatic t_reset;
    odl_fetch_model_i.put(8'he8);
    odl_fetch_model_i.idle(1);
    arst_n <= 1'b0;
    odl_fetch_model_i.idle(2);
    #1;
    chk("rst valid", 32'h0, {31'h0, dec_valid_ff});
    chk("rst len", 32'h0, {28'h0, dec_len_ff});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    ri("after rst", '{8'heb, 8'h10}, odl_op_br_short, 2, 32'h10, 1);
  endtask
  initial begin
    n_fail = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_shift();
    t_logic();
    t_string();
    t_xfer();
    t_branch();
    t_reset();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
endmodule
